/* ctpsr_pkg.sv */
// ctpsr_pkg: constants and types shared by the custom transmit pulse shaper files
package ctpsr_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int unsigned NUM_CH        = 8;
  localparam int unsigned PHASES        = 24;
  localparam int unsigned PHASES_PER_UI = 12;
  localparam int unsigned SAMPLE_W      = 7;
  localparam int unsigned REG_W         = 8;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned PH_W          = 5;
  localparam int unsigned CH_W          = 3;

  // ***************************************************************
  // register offsets, field positions, reset values
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CONTROL = 5'h0f;
  localparam logic [ADDR_W-1:0] OFS_BCAST_SELECT   = 5'h16;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_ADDRESS = 5'h17;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_DATA    = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_ENABLE  = 5'h19;

  localparam int unsigned       GCTL_AUTOINC_POS   = 7;
  localparam int unsigned       SADDR_CH_POS       = 5;
  localparam logic [REG_W-1:0]  REG_RST            = 8'h00;
  localparam logic [REG_W-1:0]  READ_UNMAPPED      = 8'h00;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST       = 7'h00;
  localparam logic [SAMPLE_W-1:0] SAMPLE_POS_MAX   = 7'h3f;
  localparam logic [SAMPLE_W-1:0] SAMPLE_NEG_MAX   = 7'h40;
  localparam logic [PH_W-1:0]   PHASE_LAST         = 5'h17;
  localparam logic [PH_W-1:0]   PHASE_FIRST        = 5'h00;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned MCLK_TIMEOUT_NS = 2000;
  // longest time, so round down
  localparam int unsigned MCLK_TIMEOUT_CYC = MCLK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned MCLK_CNT_W       = 8;
  localparam logic [MCLK_CNT_W-1:0] MCLK_CNT_LAST = 8'(MCLK_TIMEOUT_CYC - 1);

  // built-in shape: body in first unit interval, flat tail in second
  localparam logic [0:PHASES-1][SAMPLE_W-1:0] BUILTIN_SHAPE = {
    7'h00, 7'h10, 7'h28, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h28, 7'h10, 7'h00,
    7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } ctpsr_bus_t;

  typedef struct packed {
    logic [REG_W-1:0] global_control;
    logic [REG_W-1:0] shape_broadcast_select;
    logic [REG_W-1:0] shape_sample_address;
    logic [REG_W-1:0] shape_source_enable;
  } ctpsr_regs_t;

  typedef enum logic [0:0] {
    WR_IDLE  = 1'b0,
    WR_BCAST = 1'b1
  } ctpsr_wr_state_t;

  typedef struct packed {
    ctpsr_bus_t              bus_s1;
    ctpsr_bus_t              bus_s2;
    ctpsr_bus_t              bus_s3;
    logic [2:0]              mclk_sync;
    logic [1:0]              host_sync;
    logic [MCLK_CNT_W-1:0]   mclk_cnt;
    logic                    mclk_ok;
    ctpsr_regs_t             regs;
    ctpsr_wr_state_t         wr_state;
    logic [NUM_CH-1:0]       pend;
    logic [PH_W-1:0]         wr_phase;
    logic [SAMPLE_W-1:0]     wr_val;
    logic [REG_W-1:0]        rdata;
    logic                    rd_oe;
  } ctpsr_top_st_t;

  typedef struct packed {
    logic [PH_W-1:0]     phase;
    logic                busy;
    logic                neg;
    logic [SAMPLE_W-1:0] sample;
  } ctpsr_play_st_t;

endpackage : ctpsr_pkg

/* ctpsr_player.sv */
// ctpsr_player: plays one channel's 24-phase pulse shape out in phase order
module ctpsr_player
  import ctpsr_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  // transmit request
  input  wire logic                start_i,
  input  wire logic                neg_i,
  // shape source
  input  wire logic                custom_en_i,
  input  wire logic [SAMPLE_W-1:0] custom_sample_i,
  // playout
  output logic      [PH_W-1:0]     phase_o,
  output logic      [SAMPLE_W-1:0] sample_o,
  output logic                     busy_o
);

  ctpsr_play_st_t cur_reg;
  ctpsr_play_st_t cur_next;

  // two's complement negate; the most negative code has no mirror, so it saturates
  function automatic logic [SAMPLE_W-1:0] sat_neg(input logic [SAMPLE_W-1:0] v);
    if (v == SAMPLE_NEG_MAX) begin
      return SAMPLE_POS_MAX;
    end
    return SAMPLE_W'(~v + 7'h01);
  endfunction : sat_neg

  // one phase per clock, lowest address first; source chosen live per phase
  always_comb begin
    logic [SAMPLE_W-1:0] src;
    cur_next = cur_reg;
    src      = custom_en_i ? custom_sample_i : BUILTIN_SHAPE[cur_reg.phase];
    if (cur_reg.busy) begin
      cur_next.sample = cur_reg.neg ? sat_neg(src) : src;
      if (cur_reg.phase == PHASE_LAST) begin
        cur_next.busy  = 1'b0;
        cur_next.phase = PHASE_FIRST;
      end else begin
        cur_next.phase = cur_reg.phase + 5'h01;
      end
    end else begin
      cur_next.sample = SAMPLE_RST;
      if (start_i) begin
        cur_next.busy  = 1'b1;
        cur_next.phase = PHASE_FIRST;
        cur_next.neg   = neg_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign phase_o  = cur_reg.phase;
  assign sample_o = cur_reg.sample;
  assign busy_o   = cur_reg.busy;

endmodule : ctpsr_player

/* ctpsr_top.sv */
// ctpsr_top: custom transmit pulse shaper, sample store and host register access
//
// Notes on behaviour
// - separate shape store for each of eight channels
// - store reached only through host interface
// - 24 samples, two intervals of twelve each
// - samples are signed 7-bit two's complement
// - negative pulses play inverted sample values
// - samples play out lowest phase address first
// - enable bit n picks custom shape channel n
// - address register selects phase for data accesses
// - auto-increment bit advances phase per data access
// - auto-increment never changes the channel field
// - rewriting address restarts sequence from new index
// - broadcast register has one bit per channel
// - broadcast works only while master clock runs
// - data reads ignore broadcast, use addressed channel
// - data writes hit addressed and broadcast channels
// - addressed channel written first, regardless of bit
// - address register: channel [7:5], phase [4:0]
// - soft reset keeps samples; power-up clears them
// - enable and address registers reset to zero
module ctpsr_top
  import ctpsr_pkg::*;
#(
  parameter int unsigned CH_COUNT    = NUM_CH,
  parameter int unsigned PHASE_COUNT = PHASES
)
(
  // clock and resets
  input  wire logic                              clk_i,
  input  wire logic                              nrst_i,
  input  wire logic                              soft_rst_i,
  // host interface pins
  input  wire logic                              host_mode_i,
  input  wire ctpsr_bus_t                        bus_i,
  output logic      [REG_W-1:0]                  data_o,
  output logic                                   data_oe_o,
  // master clock pin
  input  wire logic                              mclk_i,
  output logic                                   mclk_active_o,
  // transmit path
  input  wire logic [CH_COUNT-1:0]               tx_start_i,
  input  wire logic [CH_COUNT-1:0]               tx_neg_i,
  output logic      [CH_COUNT-1:0][SAMPLE_W-1:0] tx_sample_o,
  output logic      [CH_COUNT-1:0]               tx_busy_o
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  // channel field is 3 bits and the per-channel registers are 8 bits wide
  if (CH_COUNT != NUM_CH) begin : g_bad_ch
    $error("ctpsr_top: CH_COUNT must equal the channel field capacity");
  end
  // playout and address decode assume exactly two intervals of twelve
  if (PHASE_COUNT != PHASES_PER_UI * 2) begin : g_bad_ph
    $error("ctpsr_top: PHASE_COUNT must be two unit intervals");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  ctpsr_top_st_t cur_reg;
  ctpsr_top_st_t cur_next;

  // one sample store per channel, cleared only by power-up reset
  logic [SAMPLE_W-1:0] mem [NUM_CH][PHASES];

  // store write port, driven from the state decode
  logic                mem_we;
  logic [CH_W-1:0]     mem_ch;
  logic [PH_W-1:0]     mem_ph;
  logic [SAMPLE_W-1:0] mem_val;

  // host view of the addressed sample
  logic [CH_W-1:0]     addr_ch;
  logic [PH_W-1:0]     addr_ph;
  logic [SAMPLE_W-1:0] addr_sample;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // lowest set bit of a channel mask; mask is never empty when used
  function automatic logic [CH_W-1:0] low_idx(input logic [NUM_CH-1:0] v);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = CH_W'(i);
      end
    end
    return r;
  endfunction : low_idx

  // a phase index beyond the last location addresses nothing
  function automatic logic ph_ok(input logic [PH_W-1:0] p);
    return p <= PHASE_LAST;
  endfunction : ph_ok

  // next phase after a data access; channel bits are left alone
  function automatic logic [REG_W-1:0] adv_addr(input logic [REG_W-1:0] a, input logic en);
    logic [PH_W-1:0] p;
    p = a[PH_W-1:0];
    if (en) begin
      p = p + 5'h01;
    end
    return {a[REG_W-1:SADDR_CH_POS], p};
  endfunction : adv_addr

  // address register split into its two fields
  assign addr_ch     = cur_reg.regs.shape_sample_address[REG_W-1:SADDR_CH_POS];
  assign addr_ph     = cur_reg.regs.shape_sample_address[PH_W-1:0];
  // reads use only the addressed channel, whatever broadcast holds
  assign addr_sample = ph_ok(addr_ph) ? mem[addr_ch][addr_ph] : SAMPLE_RST;

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb begin
    logic            host;
    logic            sel;
    logic            rd_fall;
    logic            rd_rise;
    logic            wr_rise;
    logic            autoinc;
    logic [CH_W-1:0] bch;
    logic [NUM_CH-1:0] others;
    cur_next = cur_reg;
    mem_we   = 1'b0;
    mem_ch   = '0;
    mem_ph   = '0;
    mem_val  = '0;

    // pins pass two flops; the third copy serves edge detection and also supplies select, address and data
    cur_next.bus_s1    = bus_i;
    cur_next.bus_s2    = cur_reg.bus_s1;
    cur_next.bus_s3    = cur_reg.bus_s2;
    cur_next.mclk_sync = {cur_reg.mclk_sync[1:0], mclk_i};
    cur_next.host_sync = {cur_reg.host_sync[0], host_mode_i};

    // master clock watchdog: any edge within the timeout counts as running
    if (cur_reg.mclk_sync[1] != cur_reg.mclk_sync[2]) begin
      cur_next.mclk_cnt = '0;
      cur_next.mclk_ok  = 1'b1;
    end else if (cur_reg.mclk_cnt == MCLK_CNT_LAST) begin
      cur_next.mclk_ok  = 1'b0;
    end else begin
      cur_next.mclk_cnt = cur_reg.mclk_cnt + 8'h01;
    end

    // strobes act at their synchronised edges; address and data from the older copy
    host    = cur_reg.host_sync[1];
    sel     = host && !cur_reg.bus_s3.cs_n;
    rd_fall = sel && cur_reg.bus_s3.rd_n && !cur_reg.bus_s2.rd_n;
    rd_rise = sel && !cur_reg.bus_s3.rd_n && cur_reg.bus_s2.rd_n;
    wr_rise = sel && !cur_reg.bus_s3.wr_n && cur_reg.bus_s2.wr_n;
    autoinc = cur_reg.regs.global_control[GCTL_AUTOINC_POS];
    others  = cur_reg.regs.shape_broadcast_select & ~(8'h01 << addr_ch);
    bch     = low_idx(cur_reg.pend);

    // register writes take effect when the write strobe ends
    if (wr_rise) begin
      unique case (cur_reg.bus_s3.addr)
        OFS_GLOBAL_CONTROL: begin
          cur_next.regs.global_control = cur_reg.bus_s3.wdata;
        end
        OFS_BCAST_SELECT: begin
          cur_next.regs.shape_broadcast_select = cur_reg.bus_s3.wdata;
        end
        OFS_SAMPLE_ADDRESS: begin
          // a new address restarts the sequence from the written index
          cur_next.regs.shape_sample_address = cur_reg.bus_s3.wdata;
        end
        OFS_SOURCE_ENABLE: begin
          cur_next.regs.shape_source_enable = cur_reg.bus_s3.wdata;
        end
        OFS_SAMPLE_DATA: begin
          // a data write while broadcast copies are pending is dropped
          if (cur_reg.wr_state == WR_IDLE) begin
            // bit seven is reserved and never stored
            mem_we  = ph_ok(addr_ph);
            mem_ch  = addr_ch;
            mem_ph  = addr_ph;
            mem_val = cur_reg.bus_s3.wdata[SAMPLE_W-1:0];
            cur_next.wr_phase = addr_ph;
            cur_next.wr_val   = cur_reg.bus_s3.wdata[SAMPLE_W-1:0];
            // copies to other channels only while the master clock runs
            cur_next.pend = (ph_ok(addr_ph) && cur_reg.mclk_ok) ? others : '0;
            if (ph_ok(addr_ph) && cur_reg.mclk_ok && (others != '0)) begin
              cur_next.wr_state = WR_BCAST;
            end
            // the access used the old index; the new one applies next time
            cur_next.regs.shape_sample_address =
              adv_addr(cur_reg.regs.shape_sample_address, autoinc);
          end
        end
        default: begin
          // unmapped offsets are ignored
        end
      endcase
    end

    // broadcast copies, one channel per clock, after the addressed one
    unique case (cur_reg.wr_state)
      WR_IDLE: begin
      end
      WR_BCAST: begin
        mem_we  = 1'b1;
        mem_ch  = bch;
        mem_ph  = cur_reg.wr_phase;
        mem_val = cur_reg.wr_val;
        cur_next.pend = cur_reg.pend & ~(8'h01 << bch);
        if ((cur_reg.pend & ~(8'h01 << bch)) == '0) begin
          cur_next.wr_state = WR_IDLE;
        end
      end
    endcase

    // read data is captured when the read strobe starts and held while it lasts
    if (rd_fall) begin
      cur_next.rd_oe = 1'b1;
      unique case (cur_reg.bus_s3.addr)
        OFS_GLOBAL_CONTROL: cur_next.rdata = cur_reg.regs.global_control;
        OFS_BCAST_SELECT:   cur_next.rdata = cur_reg.regs.shape_broadcast_select;
        OFS_SAMPLE_ADDRESS: cur_next.rdata = cur_reg.regs.shape_sample_address;
        OFS_SAMPLE_DATA:    cur_next.rdata = {1'b0, addr_sample};
        OFS_SOURCE_ENABLE:  cur_next.rdata = cur_reg.regs.shape_source_enable;
        default:            cur_next.rdata = READ_UNMAPPED;
      endcase
    end

    // release the bus as soon as either strobe or select goes away
    if (cur_reg.bus_s2.rd_n || cur_reg.bus_s2.cs_n || !host) begin
      cur_next.rd_oe = 1'b0;
    end

    // a data read advances the index only once the read has ended
    if (rd_rise && (cur_reg.bus_s3.addr == OFS_SAMPLE_DATA)) begin
      cur_next.regs.shape_sample_address =
        adv_addr(cur_reg.regs.shape_sample_address, autoinc);
    end

    // software reset clears control state but leaves the sample store alone
    if (soft_rst_i) begin
      cur_next.regs     = '{default: REG_RST};
      cur_next.wr_state = WR_IDLE;
      cur_next.pend     = '0;
      cur_next.rdata    = REG_RST;
      cur_next.rd_oe    = 1'b0;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // every field resets to zero, which also gives the register defaults
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // sample store: only power-up reset clears it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int p = 0; p < PHASES; p++) begin
          mem[c][p] <= SAMPLE_RST;
        end
      end
    end else if (mem_we) begin
      mem[mem_ch][mem_ph] <= mem_val;
    end
  end

  // ***************************************************************
  // per-channel playout
  // ***************************************************************
  // each player reads its own channel's store at its current phase
  for (genvar g = 0; g < NUM_CH; g++) begin : g_play
    logic [PH_W-1:0]     ph;
    logic [SAMPLE_W-1:0] cs;
    assign cs = ph_ok(ph) ? mem[g][ph] : SAMPLE_RST;

    ctpsr_player u_player (
      .clk_i           (clk_i),
      .nrst_i          (nrst_i),
      .start_i         (tx_start_i[g]),
      .neg_i           (tx_neg_i[g]),
      .custom_en_i     (cur_reg.regs.shape_source_enable[g]),
      .custom_sample_i (cs),
      .phase_o         (ph),
      .sample_o        (tx_sample_o[g]),
      .busy_o          (tx_busy_o[g])
    );
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign data_o        = cur_reg.rdata;
  assign data_oe_o     = cur_reg.rd_oe;
  assign mclk_active_o = cur_reg.mclk_ok;

endmodule : ctpsr_top

/* ctpsr_top_chk.sv */
// ctpsr_top_chk: port-level assertions for the custom pulse shaper
module ctpsr_top_chk
  import ctpsr_pkg::*;
#(
  parameter int unsigned CH_COUNT    = NUM_CH,
  parameter int unsigned PHASE_COUNT = PHASES
)
(
  // clock and resets
  input wire logic                              clk_i,
  input wire logic                              nrst_i,
  input wire logic                              soft_rst_i,
  // host interface
  input wire logic                              host_mode_i,
  input wire ctpsr_bus_t                        bus_i,
  input wire logic [REG_W-1:0]                  data_o,
  input wire logic                              data_oe_o,
  // master clock
  input wire logic                              mclk_i,
  input wire logic                              mclk_active_o,
  // transmit path
  input wire logic [CH_COUNT-1:0]               tx_start_i,
  input wire logic [CH_COUNT-1:0]               tx_neg_i,
  input wire logic [CH_COUNT-1:0][SAMPLE_W-1:0] tx_sample_o,
  input wire logic [CH_COUNT-1:0]               tx_busy_o
);
  // ***************************************************************
  // quiet-time counter on the master clock pin
  // ***************************************************************
  logic [5:0] quiet_reg;
  logic [5:0] quiet_next;
  logic       mclk_q_reg;

  // saturates so a long stop never wraps back to looking active
  always_comb begin
    quiet_next = (mclk_i != mclk_q_reg) ? 6'h00 : quiet_reg + 6'(quiet_reg != 6'h3f);
  end

  // register the count and the last pin level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quiet_reg  <= 6'h00;
      mclk_q_reg <= 1'b0;
    end else begin
      quiet_reg  <= quiet_next;
      mclk_q_reg <= mclk_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // steps of a playout and of a read strobe
  sequence s_busy8;
    tx_busy_o[0] [*8];
  endsequence
  sequence s_rd_req;
    !bus_i.cs_n && host_mode_i && $fell(bus_i.rd_n);
  endsequence

  property p_start;
    tx_start_i[0] && !tx_busy_o[0] |=> tx_busy_o[0];
  endproperty
  a_start: assert property (p_start) else $error("idle start not taken");
  property p_len;
    $rose(tx_busy_o[0]) |-> s_busy8 ##16 tx_busy_o[0] ##1 !tx_busy_o[0];
  endproperty
  a_len: assert property (p_len) else $error("playout not 24 cycles");
  property p_idle;
    !tx_busy_o[0] && !$past(tx_busy_o[0]) |-> tx_sample_o[0] == 7'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("sample while idle");
  property p_oe_rd;
    s_rd_req |-> ##[1:5] data_oe_o;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("read not answered");
  property p_oe_idle;
    bus_i.cs_n [*6] |-> !data_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data bus driven unselected");
  property p_mclk_stop;
    quiet_reg >= 6'd26 |-> !mclk_active_o;
  endproperty
  a_mclk_stop: assert property (p_mclk_stop) else $error("stopped clock seen active");
  property p_mclk_run;
    $rose(mclk_active_o) |-> quiet_reg <= 6'd8;
  endproperty
  a_mclk_run: assert property (p_mclk_run) else $error("active without clock edges");
  property p_rst;
    $rose(nrst_i) |-> !data_oe_o && !mclk_active_o && tx_busy_o == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_soft;
    soft_rst_i |=> !data_oe_o && data_o == REG_RST;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left read path");
endmodule : ctpsr_top_chk

bind ctpsr_top ctpsr_top_chk #(.CH_COUNT(CH_COUNT), .PHASE_COUNT(PHASE_COUNT)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i), .host_mode_i(host_mode_i),
  .bus_i(bus_i), .data_o(data_o), .data_oe_o(data_oe_o), .mclk_i(mclk_i),
  .mclk_active_o(mclk_active_o), .tx_start_i(tx_start_i), .tx_neg_i(tx_neg_i),
  .tx_sample_o(tx_sample_o), .tx_busy_o(tx_busy_o));

/* test_custom_tx_pulse_shape_ram.sv */
// test_custom_tx_pulse_shape_ram: directed bench for the custom pulse shaper
module test_custom_tx_pulse_shape_ram
  import ctpsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************************
  // signals, clocks, design
  // ***************************************************************
  logic                  clk_i = 1'b0;
  logic                  nrst_i = 1'b0;
  logic                  soft_rst_i = 1'b0;
  logic                  host_mode_i = 1'b1;
  ctpsr_bus_t            bus_i = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
  logic                  mclk_i = 1'b0;
  logic                  mclk_run = 1'b0;
  logic [7:0]            tx_start_i = 8'h00;
  logic [7:0]            tx_neg_i = 8'h00;
  logic [7:0]            data_o;
  logic                  data_oe_o;
  logic                  mclk_active_o;
  logic [7:0][6:0]       tx_sample_o;
  logic [7:0]            tx_busy_o;
  int                    errors = 0;
  int                    checked = 0;

  // clocks: master clock phase unrelated to clk_i, stands still when stopped
  always #50 clk_i = ~clk_i;
  always #230 if (mclk_run) mclk_i = ~mclk_i;

  ctpsr_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i), .host_mode_i(host_mode_i),
    .bus_i(bus_i), .data_o(data_o), .data_oe_o(data_oe_o), .mclk_i(mclk_i),
    .mclk_active_o(mclk_active_o), .tx_start_i(tx_start_i), .tx_neg_i(tx_neg_i),
    .tx_sample_o(tx_sample_o), .tx_busy_o(tx_busy_o));

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // inputs other than mclk_i move 1 ns after a rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  // strobes held 4 clk, since the pins pass a 2-flop synchroniser
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus_i.cs_n = 1'b0;
    bus_i.addr = a;
    bus_i.wdata = d;
    idle(4);
    bus_i.wr_n = 1'b0;
    idle(4);
    bus_i.wr_n = 1'b1;
    idle(4);
    bus_i.cs_n = 1'b1;
    idle(12);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    bus_i.cs_n = 1'b0;
    bus_i.addr = a;
    idle(4);
    bus_i.rd_n = 1'b0;
    idle(6);
    chk({7'h00, data_oe_o}, 8'h01);
    chk(data_o, exp);
    bus_i.rd_n = 1'b1;
    idle(5);
    bus_i.cs_n = 1'b1;
    idle(4);
  endtask : rd

  task automatic put(input logic [2:0] ch, input logic [4:0] ph, input logic [6:0] v);
    wr(OFS_SAMPLE_ADDRESS, {ch, ph});
    wr(OFS_SAMPLE_DATA, {1'b0, v});
  endtask : put

  task automatic get(input logic [2:0] ch, input logic [4:0] ph, input logic [6:0] v);
    wr(OFS_SAMPLE_ADDRESS, {ch, ph});
    rd(OFS_SAMPLE_DATA, {1'b0, v});
  endtask : get

  // test shape: both extreme codes early, flat second interval
  function automatic logic [6:0] shape(input int k);
    if (k == 1) return SAMPLE_POS_MAX;
    if (k == 2) return SAMPLE_NEG_MAX;
    return (k < 12) ? 7'(k * 5) : 7'h00;
  endfunction : shape

  function automatic logic [6:0] inv(input logic [6:0] v);
    return (v == 7'h40) ? 7'h3f : ~v + 7'h01;
  endfunction : inv

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    rd(OFS_SAMPLE_ADDRESS, 8'h00);
    rd(OFS_SOURCE_ENABLE, 8'h00);
    rd(5'h1a, READ_UNMAPPED);
    chk({7'h00, mclk_active_o}, 8'h00);
  endtask : t_reset

  task automatic t_load();
    wr(OFS_GLOBAL_CONTROL, 8'h80);
    wr(OFS_SAMPLE_ADDRESS, 8'h40);
    for (int k = 0; k < 24; k++) wr(OFS_SAMPLE_DATA, {1'b0, shape(k)});
    wr(OFS_SOURCE_ENABLE, 8'h04);
    wr(OFS_SAMPLE_ADDRESS, 8'h40);
    for (int k = 0; k < 3; k++) rd(OFS_SAMPLE_DATA, {1'b0, shape(k)});
    rd(OFS_SAMPLE_ADDRESS, 8'h43);
    wr(OFS_SAMPLE_ADDRESS, 8'h49);
    rd(OFS_SAMPLE_DATA, {1'b0, shape(9)});
  endtask : t_load

  // channel 2 custom and channel 0 built-in start on the same cycle
  task automatic t_play(input logic neg);
    tx_neg_i = {8{neg}};
    tx_start_i = 8'h05;
    idle(1);
    tx_start_i = 8'h00;
    chk(tx_busy_o, 8'h05);
    // phase k stands from the (k+1)th edge after the start edge
    for (int k = 0; k < 24; k++) begin
      idle(1);
      chk(tx_sample_o[2], neg ? inv(shape(k)) : shape(k));
      chk(tx_sample_o[0], neg ? inv(BUILTIN_SHAPE[k]) : BUILTIN_SHAPE[k]);
    end
    idle(4);
    chk(tx_busy_o, 8'h00);
  endtask : t_play

  task automatic t_bcast();
    mclk_run = 1'b1;
    idle(40);
    chk({7'h00, mclk_active_o}, 8'h01);
    wr(OFS_GLOBAL_CONTROL, 8'h00);
    wr(OFS_BCAST_SELECT, 8'h30);
    put(3'd1, 5'd7, 7'h15);
    get(3'd1, 5'd7, 7'h15);
    get(3'd4, 5'd7, 7'h15);
    get(3'd5, 5'd7, 7'h15);
    get(3'd3, 5'd7, 7'h00);
    get(3'd2, 5'd7, shape(7));
    mclk_run = 1'b0;
    idle(40);
    chk({7'h00, mclk_active_o}, 8'h00);
    put(3'd1, 5'd8, 7'h22);
    get(3'd4, 5'd8, 7'h00);
    get(3'd1, 5'd8, 7'h22);
  endtask : t_bcast

  task automatic t_soft();
    host_mode_i = 1'b0;
    idle(3);
    wr(OFS_SOURCE_ENABLE, 8'hff);
    host_mode_i = 1'b1;
    idle(3);
    rd(OFS_SOURCE_ENABLE, 8'h04);
    soft_rst_i = 1'b1;
    idle(1);
    soft_rst_i = 1'b0;
    idle(2);
    rd(OFS_SOURCE_ENABLE, 8'h00);
    rd(OFS_SAMPLE_ADDRESS, 8'h00);
    get(3'd2, 5'd1, SAMPLE_POS_MAX);
  endtask : t_soft

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence: reset held 10 cycles
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    idle(2);
    t_reset();
    t_load();
    t_play(1'b0);
    t_play(1'b1);
    t_bcast();
    t_soft();
    end_of_test();
  end

  // watchdog: run needs about 1600 cycles, allow about six times that
  initial begin
    #1_000_000;
    errors++;
    end_of_test();
  end
endmodule : test_custom_tx_pulse_shape_ram
